// *** cieac_pkg.sv ***
// Constants, register map and carrier types for the CAN interrupt enable
// and arbitration-lost capture block.
// Assumes an APB3 master with 32-bit data and a 100 MHz system clock.
package cieac_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  FLAG_IDX  = 8'h03;
    localparam logic [7:0]  IE_IDX    = 8'h04;
    localparam logic [7:0]  CAP_IDX   = 8'h0B;
    localparam logic [31:0] FLAG_ADDR = {22'h000000, FLAG_IDX, 2'h0};
    localparam logic [31:0] IE_ADDR   = {22'h000000, IE_IDX, 2'h0};
    localparam logic [31:0] CAP_ADDR  = {22'h000000, CAP_IDX, 2'h0};

    // Source positions in the enable and flag registers
    localparam int BIT_BUS_ERR  = 7;
    localparam int BIT_ARB_LOST = 6;
    localparam int BIT_ERR_PASS = 5;
    localparam int BIT_UNUSED   = 4;
    localparam int BIT_OVERRUN  = 3;
    localparam int BIT_ERR_WARN = 2;
    localparam int BIT_TRANSMIT = 1;
    localparam int BIT_RECEIVE  = 0;

    // Capture field layout
    localparam int CAP_W   = 5;
    localparam int IDBIT_W = 6;

    // Reset values and write mask
    localparam logic [7:0]       IE_RST   = 8'h00;
    localparam logic [7:0]       IE_MASK  = 8'hEF;
    localparam logic [CAP_W-1:0] CAP_RST  = 5'h00;
    localparam logic             FLAG_RST = 1'h0;

    typedef enum logic [1:0] {
        CIEAC_PH_IDLE = 2'h1,
        CIEAC_PH_ANS  = 2'h2
    } cieac_phase_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } cieac_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } cieac_apb_rsp_t;

    typedef struct packed {
        logic bus_error;
        logic arb_lost;
        logic error_passive;
        logic overrun;
        logic error_warning;
        logic transmit;
    } cieac_evt_t;

    typedef struct packed {
        logic flag;
    } cieac_cell_st_t;

    typedef struct packed {
        cieac_phase_t     phase;
        logic [7:0]       ie;
        logic             rx_flag;
        logic [CAP_W-1:0] cap_val;
        logic             cap_full;
        logic             cap_seen;
        logic             irq;
        cieac_apb_rsp_t   rsp;
    } cieac_state_t;

    localparam cieac_apb_rsp_t RSP_IDLE = '{pready: 1'h0, prdata: 32'h00000000,
                                           pslverr: 1'h0};

    localparam cieac_state_t ST_RST = '{phase: CIEAC_PH_IDLE, ie: IE_RST,
                                        rx_flag: FLAG_RST, cap_val: CAP_RST,
                                        cap_full: 1'h0, cap_seen: 1'h0,
                                        irq: 1'h0, rsp: RSP_IDLE};

endpackage : cieac_pkg

// *** cieac_flag_cell.sv ***
// One sticky interrupt flag: set by an enabled event, cleared by a clear
// pulse. Set and clear come from logic on the same clock.
`timescale 1ns/100ps
module cieac_flag_cell #(
    parameter logic RESET_VAL = cieac_pkg::FLAG_RST
) (
    input  logic clk_sys,
    input  logic rst_n,
    input  logic enable,
    input  logic set_evt,
    input  logic clr,
    output logic flag
);

    cieac_pkg::cieac_cell_st_t st_reg;
    cieac_pkg::cieac_cell_st_t st_next;

    always_comb begin
        st_next = st_reg;
        // Set wins so an event in the clearing cycle is kept
        st_next.flag = (st_reg.flag && !clr) || (set_evt && enable);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg.flag <= RESET_VAL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag = st_reg.flag;

    default clocking cb_cell @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_cell_masked: assert property (
        !enable && !flag |=> !flag
    ) else $error("Flag rose while its source was disabled");

    a_cell_setwin: assert property (
        set_evt && enable |=> flag
    ) else $error("Enabled event lost by the flag");

endmodule : cieac_flag_cell

// *** cieac_top.sv ***
// Interrupt enable, interrupt flags and arbitration-lost capture of a
// CAN controller, reached over APB.
// Assumes event strobes and the bit position come from logic on clk_sys.
//
// Contract
// - A source flag sets, and raises the interrupt, only while enabled.
// - Enable bit 7 gates the bus error source.
// - Enable bit 6 gates the arbitration lost source.
// - Enable bit 5 gates the error passive source.
// - Enable bit 4 is unused and gates no source.
// - Enable bit 3 gates the data overrun source.
// - Enable bit 2 gates the error warning source.
// - Enable bit 1 gates transmit, bit 0 gates receive.
// - On arbitration loss the bit position is latched into the capture.
// - A latched capture holds until software reads it.
// - Capture sits in bits 4..0; bits 7..5 read zero.
// - Captured value is identifier bit number minus one, 0 to 31.
// - Arbitration lost flag sets on loss when its enable is set.
// - Reading flags clears them, except receive, cleared when FIFO empties.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
module cieac_top (
    input  logic                           clk_sys,
    input  logic                           rst_n,
    input  cieac_pkg::cieac_apb_req_t      apb_req,
    output cieac_pkg::cieac_apb_rsp_t      apb_rsp,
    input  cieac_pkg::cieac_evt_t          evt,
    input  logic [cieac_pkg::IDBIT_W-1:0]  lost_bit_position,
    input  logic                           rx_fifo_not_empty,
    output logic                           irq
);

    cieac_pkg::cieac_state_t st_reg;
    cieac_pkg::cieac_state_t st_next;

    wire logic [7:0] flag_w;
    logic      [7:0] set_v;
    logic      [7:0] clr_v;

    logic setup;
    logic done;
    logic hit_flag;
    logic hit_ie;
    logic hit_cap;
    logic flag_rd_done;
    logic ie_wr_done;
    logic cap_rd_done;
    logic cap_armed;
    logic [cieac_pkg::CAP_W-1:0] cap_new;
    logic [31:0] rd_val;

    // Request decode
    always_comb begin
        setup    = apb_req.psel && !apb_req.penable;
        done     = apb_req.psel && apb_req.penable && st_reg.rsp.pready;
        hit_flag = apb_req.paddr[31:2] == cieac_pkg::FLAG_ADDR[31:2];
        hit_ie   = apb_req.paddr[31:2] == cieac_pkg::IE_ADDR[31:2];
        hit_cap  = apb_req.paddr[31:2] == cieac_pkg::CAP_ADDR[31:2];
        flag_rd_done = done && !apb_req.pwrite && hit_flag;
        ie_wr_done   = done && apb_req.pwrite && hit_ie;
        cap_rd_done  = done && !apb_req.pwrite && hit_cap;
    end

    // Event vector in enable-register bit order
    always_comb begin
        set_v = 8'h00;
        set_v[cieac_pkg::BIT_BUS_ERR]  = evt.bus_error;
        set_v[cieac_pkg::BIT_ARB_LOST] = evt.arb_lost;
        set_v[cieac_pkg::BIT_ERR_PASS] = evt.error_passive;
        set_v[cieac_pkg::BIT_OVERRUN]  = evt.overrun;
        set_v[cieac_pkg::BIT_ERR_WARN] = evt.error_warning;
        set_v[cieac_pkg::BIT_TRANSMIT] = evt.transmit;
    end

    always_comb begin
        clr_v = 8'h00;
        if (flag_rd_done) begin
            // Only bits actually returned are cleared; newer events survive
            clr_v = st_reg.rsp.prdata[7:0];
        end
        clr_v[cieac_pkg::BIT_RECEIVE] = 1'h0;
    end

    genvar gi;
    generate
        for (gi = 1; gi < 8; gi++) begin : g_src
            if (gi != cieac_pkg::BIT_UNUSED) begin : g_cell
                cieac_flag_cell #(
                    .RESET_VAL (cieac_pkg::FLAG_RST)
                ) u_cell (
                    .clk_sys (clk_sys),
                    .rst_n   (rst_n),
                    .enable  (st_reg.ie[gi]),
                    .set_evt (set_v[gi]),
                    .clr     (clr_v[gi]),
                    .flag    (flag_w[gi])
                );
            end
        end
    endgenerate

    assign flag_w[cieac_pkg::BIT_UNUSED]  = 1'h0;
    assign flag_w[cieac_pkg::BIT_RECEIVE] = st_reg.rx_flag;

    // Read multiplexer
    always_comb begin
        rd_val = 32'h00000000;
        if (hit_flag) begin
            rd_val[7:0] = flag_w;
        end else if (hit_ie) begin
            rd_val[7:0] = st_reg.ie;
        end else if (hit_cap) begin
            rd_val[cieac_pkg::CAP_W-1:0] = st_reg.cap_val;
        end
    end

    always_comb begin
        cap_new = cieac_pkg::CAP_W'(lost_bit_position - 6'h01);
    end

    always_comb begin
        // Only a read that returned a held value releases the latch
        cap_armed = !st_reg.cap_full || (cap_rd_done && st_reg.cap_seen);
    end

    always_comb begin
        st_next = st_reg;

        case (st_reg.phase)
            cieac_pkg::CIEAC_PH_IDLE: begin
                if (setup) begin
                    st_next.phase       = cieac_pkg::CIEAC_PH_ANS;
                    st_next.rsp.pready  = 1'h1;
                    st_next.rsp.pslverr = !(hit_flag || hit_ie || hit_cap);
                    st_next.rsp.prdata  = apb_req.pwrite ? 32'h00000000 : rd_val;
                    st_next.cap_seen    = st_reg.cap_full;
                end
            end
            cieac_pkg::CIEAC_PH_ANS: begin
                if (done || !apb_req.psel) begin
                    st_next.phase = cieac_pkg::CIEAC_PH_IDLE;
                    st_next.rsp   = cieac_pkg::RSP_IDLE;
                end
            end
            default: begin
                st_next.phase = cieac_pkg::CIEAC_PH_IDLE;
                st_next.rsp   = cieac_pkg::RSP_IDLE;
            end
        endcase

        if (ie_wr_done) begin
            st_next.ie = apb_req.pwdata[7:0] & cieac_pkg::IE_MASK;
        end

        st_next.rx_flag = rx_fifo_not_empty && st_reg.ie[cieac_pkg::BIT_RECEIVE];

        if (cap_rd_done && st_reg.cap_seen) begin
            st_next.cap_full = 1'h0;
        end
        if (evt.arb_lost && cap_armed) begin
            st_next.cap_val  = cap_new;
            st_next.cap_full = 1'h1;
        end

        st_next.irq = |flag_w;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg <= cieac_pkg::ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign apb_rsp = st_reg.rsp;
    assign irq     = st_reg.irq;

    default clocking cb_top @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_ie_write;
        ie_wr_done;
    endsequence

    sequence s_cap_read;
        cap_rd_done && st_reg.cap_seen && !evt.arb_lost;
    endsequence

    sequence s_flag_read_quiet;
        flag_rd_done && set_v == 8'h00;
    endsequence

    a_buserr_gate: assert property (
        $rose(flag_w[7]) |-> $past(st_reg.ie[7]) && $past(evt.bus_error)
    ) else $error("Bus error flag set without enable and event");

    a_arblost_set: assert property (
        evt.arb_lost && st_reg.ie[6] |=> flag_w[6]
    ) else $error("Arbitration lost flag not set on enabled loss");

    a_arblost_masked: assert property (
        !st_reg.ie[6] && !flag_w[6] |=> !flag_w[6]
    ) else $error("Arbitration lost flag set while disabled");

    a_errpass_set: assert property (
        evt.error_passive && st_reg.ie[5] |=> flag_w[5]
    ) else $error("Error passive flag not set on enabled event");

    a_bit4_dead: assert property (
        s_ie_write |=> !st_reg.ie[4] && !flag_w[4]
    ) else $error("Unused enable bit 4 became active");

    a_overrun_gate: assert property (
        $rose(flag_w[3]) |-> $past(st_reg.ie[3])
    ) else $error("Overrun flag set while disabled");

    a_errwarn_set: assert property (
        evt.error_warning && st_reg.ie[2] |=> flag_w[2]
    ) else $error("Error warning flag not set on enabled event");

    a_rx_level: assert property (
        rx_fifo_not_empty && st_reg.ie[0] |=> flag_w[0] ##1 (flag_w[0] || !$past(rx_fifo_not_empty)
                                                            || !$past(st_reg.ie[0]))
    ) else $error("Receive flag does not follow FIFO level");

    a_cap_take: assert property (
        evt.arb_lost && !st_reg.cap_full |=> st_reg.cap_full
                                             && st_reg.cap_val == $past(cap_new)
    ) else $error("Arbitration loss not latched");

    a_cap_value: assert property (
        evt.arb_lost && !st_reg.cap_full && lost_bit_position == 6'h20
        |=> st_reg.cap_val == 5'h1F
    ) else $error("Identifier bit 32 not captured as 31");

    a_cap_hold: assert property (
        st_reg.cap_full && !cap_rd_done |=> $stable(st_reg.cap_val) && st_reg.cap_full
    ) else $error("Capture changed before being read");

    a_cap_rsv: assert property (
        setup && hit_cap && !apb_req.pwrite
        |=> apb_rsp.pready && apb_rsp.prdata[31:5] == 27'h0000000
    ) else $error("Capture reserved bits not zero");

    a_cap_rearm: assert property (
        s_cap_read |=> !st_reg.cap_full ##1 (!$past(evt.arb_lost) || st_reg.cap_full)
    ) else $error("Capture not reopened after read");

    a_flag_rdclr: assert property (
        s_flag_read_quiet |=> (flag_w[7:1] & $past(apb_rsp.prdata[7:1])) == 7'h00
    ) else $error("Read flags not cleared");

    a_irq_flags: assert property (
        |flag_w |=> irq
    ) else $error("Interrupt not raised for a set flag");

    a_buserr_set: assert property (
        evt.bus_error && st_reg.ie[7] |=> flag_w[7]
    ) else $error("Bus error flag not set on enabled event");

    a_overrun_set: assert property (
        evt.overrun && st_reg.ie[3] |=> flag_w[3]
    ) else $error("Overrun flag not set on enabled event");

    a_transmit_set: assert property (
        evt.transmit && st_reg.ie[1] |=> flag_w[1]
    ) else $error("Transmit flag not set on enabled event");

    a_errwarn_masked: assert property (
        !st_reg.ie[2] && !flag_w[2] |=> !flag_w[2]
    ) else $error("Error warning flag set while disabled");

    a_rx_noclear: assert property (
        flag_rd_done && rx_fifo_not_empty && st_reg.ie[0] |=> flag_w[0]
    ) else $error("Receive flag cleared by a read");

    a_apb_answer: assert property (
        setup |=> apb_rsp.pready ##1 !apb_rsp.pready
    ) else $error("APB answer not given in one access cycle");

endmodule : cieac_top

// *** cieac_evt_model.sv ***
// Far-side model: bit-stream processor event strobes and receive FIFO level.
// Assumes its tasks are called from a bench process running on clk_sys.
`timescale 1ns/100ps
module cieac_evt_model (
    input  wire logic                     clk_sys,
    output cieac_pkg::cieac_evt_t         evt,
    output logic [cieac_pkg::IDBIT_W-1:0] lost_bit_position,
    output logic                          rx_fifo_not_empty
);
    initial begin
        evt = '0;
        lost_bit_position = 6'h2A;
        rx_fifo_not_empty = 1'h0;
    end

    task automatic pulse(input cieac_pkg::cieac_evt_t e, input logic [5:0] pos);
        @(posedge clk_sys);
        evt <= e;
        lost_bit_position <= pos;
        @(posedge clk_sys);
        evt <= '0;
        // Stale outside the strobe: inverted so no match by luck
        lost_bit_position <= ~pos;
    endtask : pulse

    task automatic fifo(input logic lvl);
        @(posedge clk_sys);
        rx_fifo_not_empty <= lvl;
    endtask : fifo
endmodule : cieac_evt_model

// *** testbench.sv ***
// Self-checking bench for the interrupt enable and capture block.
// Assumes one 100 MHz clock; bench is the APB master, model the far side.
`timescale 1ns/100ps
module testbench;
    logic                          clk_sys;
    logic                          rst_n;
    cieac_pkg::cieac_apb_req_t     req;
    cieac_pkg::cieac_apb_rsp_t     apb_rsp;
    cieac_pkg::cieac_evt_t         evt;
    logic [cieac_pkg::IDBIT_W-1:0] pos;
    logic                          fifo_ne;
    logic                          irq;
    int                            failures;
    int                            cmp_count;
    logic [31:0]                   q;
    logic                          e;

    cieac_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(req), .apb_rsp(apb_rsp),
        .evt(evt), .lost_bit_position(pos), .rx_fifo_not_empty(fifo_ne), .irq(irq));
    cieac_evt_model ev_u (.clk_sys(clk_sys), .evt(evt), .lost_bit_position(pos),
        .rx_fifo_not_empty(fifo_ne));

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    // Request held until pready is sampled high with penable
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys);
        req.penable <= 1'h1;
        // Ends when pready is seen high; without an answer only the watchdog ends this wait
        do begin
            @(posedge clk_sys);
        end while (apb_rsp.pready !== 1'h1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h00000000);
        chk(nm, q, x);
    endtask : rd

    task automatic irq_is(input logic x);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("irq", {31'h0, irq}, {31'h0, x});
    endtask : irq_is

    task automatic t_reset;
        chk("irq", {31'h0, irq}, 32'h00000000);
        rd("ie", cieac_pkg::IE_ADDR, 32'h00000000);
        rd("cap", cieac_pkg::CAP_ADDR, 32'h00000000);
        rd("flags", cieac_pkg::FLAG_ADDR, 32'h00000000);
    endtask : t_reset

    task automatic t_enable_reg;
        apb(1'h1, cieac_pkg::IE_ADDR, 32'hFFFFFFFF);
        rd("ie", cieac_pkg::IE_ADDR, 32'h000000EF);
        apb(1'h1, cieac_pkg::IE_ADDR, 32'h00000010);
        rd("ie", cieac_pkg::IE_ADDR, 32'h00000000);
    endtask : t_enable_reg

    task automatic t_capture;
        int ids[4] = '{1, 2, 17, 32};
        cieac_pkg::cieac_evt_t al;
        al = '{arb_lost: 1'h1, default: 1'h0};
        foreach (ids[i]) begin
            ev_u.pulse(al, 6'(ids[i]));
            rd("cap", cieac_pkg::CAP_ADDR, 32'(ids[i] - 1));
        end
        ev_u.pulse(al, 6'h0A);
        ev_u.pulse(al, 6'h14);
        apb(1'h1, cieac_pkg::CAP_ADDR, 32'hFFFFFFFF);
        chk("err", {31'h0, e}, 32'h00000000);
        rd("cap", cieac_pkg::CAP_ADDR, 32'h00000009);
        ev_u.pulse(al, 6'h14);
        rd("cap", cieac_pkg::CAP_ADDR, 32'h00000013);
    endtask : t_capture

    // Each strobe against every other enable, then against its own
    task automatic t_sources;
        int bits[6] = '{7, 6, 5, 3, 2, 1};
        cieac_pkg::cieac_evt_t ev;
        for (int i = 0; i < 6; i++) begin
            ev = cieac_pkg::cieac_evt_t'(6'h20 >> i);
            apb(1'h1, cieac_pkg::IE_ADDR, {24'h0, cieac_pkg::IE_MASK ^ (8'h01 << bits[i])});
            ev_u.pulse(ev, 6'h03);
            irq_is(1'h0);
            rd("flags", cieac_pkg::FLAG_ADDR, 32'h00000000);
            apb(1'h1, cieac_pkg::IE_ADDR, 32'h00000001 << bits[i]);
            ev_u.pulse(ev, 6'h03);
            irq_is(1'h1);
            rd("flags", cieac_pkg::FLAG_ADDR, 32'h00000001 << bits[i]);
            rd("flags", cieac_pkg::FLAG_ADDR, 32'h00000000);
            irq_is(1'h0);
        end
    endtask : t_sources

    task automatic t_receive;
        apb(1'h1, cieac_pkg::IE_ADDR, 32'h00000001);
        ev_u.fifo(1'h1);
        irq_is(1'h1);
        rd("flags", cieac_pkg::FLAG_ADDR, 32'h00000001);
        rd("flags", cieac_pkg::FLAG_ADDR, 32'h00000001);
        ev_u.fifo(1'h0);
        rd("flags", cieac_pkg::FLAG_ADDR, 32'h00000000);
        apb(1'h1, cieac_pkg::IE_ADDR, 32'h00000000);
        ev_u.fifo(1'h1);
        rd("flags", cieac_pkg::FLAG_ADDR, 32'h00000000);
        ev_u.fifo(1'h0);
    endtask : t_receive

    task automatic t_unmapped;
        apb(1'h0, 32'h00000014, 32'h00000000);
        chk("err", {31'h0, e}, 32'h00000001);
        chk("data", q, 32'h00000000);
        apb(1'h1, 32'h00000014, 32'h000000FF);
        rd("ie", cieac_pkg::IE_ADDR, 32'h00000000);
    endtask : t_unmapped

    task automatic t_midreset;
        cieac_pkg::cieac_evt_t ev;
        ev = '{bus_error: 1'h1, arb_lost: 1'h1, default: 1'h0};
        rd("cap", cieac_pkg::CAP_ADDR, 32'h00000002);
        apb(1'h1, cieac_pkg::IE_ADDR, 32'h000000EF);
        ev_u.pulse(ev, 6'h08);
        irq_is(1'h1);
        @(posedge clk_sys);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        t_reset();
    endtask : t_midreset

    initial begin
        failures = 0;
        cmp_count = 0;
        rst_n = 1'h0;
        req = '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        t_reset();
        t_enable_reg();
        t_capture();
        t_sources();
        t_receive();
        t_unmapped();
        t_midreset();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        test_done();
    end
endmodule : testbench
